/* File: i2c_target_register_access_test.sv */
`timescale 1ns/1ps

// ==========
// bench: host model drives the bus, a register file answers reads
module i2c_target_register_access_test;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [1:0]  sel_mode = 2'h0;
   logic [15:0] rdata = 16'h0000;
   logic        scl, sda_pull, sda_o, sda_oe, reg_wr, reg_rd, sw_rst;
   logic [7:0]  reg_addr, c;
   logic [15:0] reg_wdata, d, v;
   logic [6:0]  taddr, ta;
   logic [2:0]  k;
   logic [15:0] regf [256];
   int          exp_mem [int];
   int          num_errors = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          wr_cnt = 0;
   int          rs_cnt = 0;
   int          rd_cnt = 0;
   int          scl_cnt = 0;
   int          wr_scl = 0;
   logic        scl_q = 1'b1;
   wire         sda_wire = ~(sda_pull | sda_oe);
   // strap pin tied to ground, supply, sda or scl
   wire         sel_pin = sel_mode[1] ? (sel_mode[0] ? scl : sda_wire) : sel_mode[0];

   i2ct_host i2ct_host_i (.clk(mclk), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));
   i2ct_target i2ct_target_i (.MCLK(mclk), .RST(rst), .SCL_I(scl), .SDA_I(sda_wire),
      .SDA_O(sda_o), .SDA_OE(sda_oe), .ADDRESS_SELECT_PIN(sel_pin), .REG_ADDR(reg_addr),
      .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(rdata),
      .TARGET_ADDR(taddr), .SW_RESET(sw_rst));

   always #12.5 mclk = ~mclk;

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // register file, strobe counters and hang limit
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      rdata <= regf[reg_addr];
      // scl rises seen so far, and where the write strobe fell among them
      scl_q <= scl;
      if (scl && !scl_q) scl_cnt <= scl_cnt + 1;
      if (reg_rd) rd_cnt <= rd_cnt + 1;
      if (reg_wr) begin
         regf[reg_addr] <= reg_wdata;
         wr_cnt <= wr_cnt + 1;
         wr_scl <= scl_cnt;
      end
      if (sw_rst) rs_cnt <= rs_cnt + 1;
      if (cycles == 60000) begin
         num_errors++;
         print_verdict();
      end
   end

   // one frame: acks per byte, writes and soft resets it should cause
   task automatic frame(input logic [7:0] b[$], input logic [7:0] ea, input int ew, input int er);
      logic [7:0] k8;
      int         w0;
      int         r0;
      int         s0;
      k8 = 8'h00;
      w0 = wr_cnt;
      r0 = rs_cnt;
      s0 = scl_cnt;
      i2ct_host_i.start();
      foreach (b[i]) i2ct_host_i.tx(b[i], k8[i]);
      i2ct_host_i.stop();
      check(16'(k8), 16'(ea));
      check(16'(wr_cnt - w0), 16'(ew));
      check(16'(rs_cnt - r0), 16'(er));
      // the update must land only after the full four-byte frame
      if (ew != 0) check(16'(wr_scl - s0), 16'(i2ct_pkg::FRAME_CLOCKS));
      check(16'(sda_o), 16'h0000);
   endtask : frame

   task automatic rd_reg(input logic [6:0] a, input logic [7:0] cmd, output logic [15:0] r,
                         output logic [2:0] ka);
      int r0;
      r0 = rd_cnt;
      i2ct_host_i.start();
      i2ct_host_i.tx({a, 1'b0}, ka[2]);
      i2ct_host_i.tx(cmd, ka[1]);
      i2ct_host_i.start();
      i2ct_host_i.tx({a, 1'b1}, ka[0]);
      i2ct_host_i.rx(r[15:8], 1'b1);
      i2ct_host_i.rx(r[7:0], 1'b0);
      i2ct_host_i.stop();
      check(16'(rd_cnt - r0), 16'h0001);
   endtask : rd_reg

   // main sequence
   initial begin
      foreach (regf[i]) regf[i] = 16'h0000;
      void'($urandom(93));
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      repeat (5) @(posedge mclk);
      check(16'(taddr), 16'h0048);
      // every strap: random write then read back
      for (int s = 0; s < 4; s++) begin
         sel_mode <= 2'(s);
         ta = {i2ct_pkg::ADDR_PREFIX, 3'(s)};
         c = 8'($urandom);
         d = 16'($urandom);
         frame('{{ta, 1'b0}, c, d[15:8], d[7:0]}, 8'h0F, 1, 0);
         exp_mem[c] = d;
         check(16'(taddr), 16'(ta));
         check(16'(reg_addr), 16'(c));
         check(reg_wdata, 16'(exp_mem[c]));
         rd_reg(ta, c, v, k);
         check(16'(k), 16'h0007);
         check(v, 16'(exp_mem[c]));
         $display("strap test %0d done", s);
      end
      // refusals, broadcast and general call
      sel_mode <= 2'h0;
      ta = {i2ct_pkg::ADDR_PREFIX, 3'h0};
      d = 16'($urandom);
      frame('{{ta ^ 7'h05, 1'b0}, 8'h01, 8'h00, 8'h00}, 8'h00, 0, 0);
      frame('{{ta, 1'b0}, 8'h02, d[15:8]}, 8'h07, 0, 0);
      frame('{8'hF0, 8'h00}, 8'h00, 0, 0);
      frame('{{i2ct_pkg::BCAST_ADDR, 1'b0}, 8'h03, d[15:8], d[7:0], 8'h55}, 8'h0F, 1, 0);
      check(reg_wdata, d);
      frame('{{i2ct_pkg::BCAST_ADDR, 1'b1}}, 8'h00, 0, 0);
      frame('{8'h00, 8'h07}, 8'h01, 0, 0);
      frame('{8'h00, 8'h06}, 8'h03, 0, 1);
      $display("refusal test done");
      print_verdict();
   end
endmodule : i2c_target_register_access_test

bind i2ct_target i2ct_target_props i2ct_target_props_i (.MCLK(MCLK), .RST(RST), .SCL_I(SCL_I),
   .SDA_I(SDA_I), .SDA_OE(SDA_OE), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .TARGET_ADDR(TARGET_ADDR), .SW_RESET(SW_RESET));

/* File: i2ct_host.sv */
`timescale 1ns/1ps

// ==========
// bus controller model; sda_pull high pulls the wire low, scl stands high between frames
module i2ct_host #(
   parameter int HALF = 20  // mclk per scl phase, just under 1 MHz
) (
   // clock
   input  logic clk,
   // bus lines
   input  logic sda_wire,
   output logic scl,
   output logic sda_pull
);
   // idle bus
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   task automatic half();
      repeat (HALF) @(posedge clk);
   endtask : half

   // data moves a few cycles after scl falls so no edge looks like start or stop
   task automatic pulse(input logic b, output logic v);
      repeat (4) @(posedge clk);
      sda_pull <= ~b;
      half();
      scl <= 1'b1;
      half();
      v = sda_wire;
      scl <= 1'b0;
   endtask : pulse

   // eight bits msb first, then the ninth clock for the answer
   task automatic tx(input logic [7:0] d, output logic ack);
      logic v;
      for (int i = 7; i >= 0; i--) pulse(d[i], v);
      pulse(1'b1, v);
      ack = ~v;
   endtask : tx

   // ack the high byte, not-ack the low byte
   task automatic rx(output logic [7:0] d, input logic ack);
      logic v;
      for (int i = 7; i >= 0; i--) begin
         pulse(1'b1, v);
         d[i] = v;
      end
      pulse(~ack, v);
   endtask : rx

   // start or repeated start
   task automatic start();
      repeat (4) @(posedge clk);
      sda_pull <= 1'b0;
      half();
      scl <= 1'b1;
      half();
      sda_pull <= 1'b1;
      half();
      scl <= 1'b0;
   endtask : start

   task automatic stop();
      repeat (4) @(posedge clk);
      sda_pull <= 1'b1;
      half();
      scl <= 1'b1;
      half();
      sda_pull <= 1'b0;
      half();
   endtask : stop
endmodule : i2ct_host

/* File: i2ct_pkg.sv */
package i2ct_pkg;

   // ==================================================================
   // address byte layout
   localparam logic [3:0] ADDR_PREFIX   = 4'h9;   // fixed upper target bits 1001
   localparam logic [6:0] BCAST_ADDR    = 7'h47;  // broadcast target 1000111, write only
   localparam logic [7:0] GCALL_BYTE    = 8'h00;  // general-call address byte
   localparam logic [7:0] GCALL_RESET   = 8'h06;  // general-call software reset code
   localparam int         RW_BIT        = 0;      // direction bit position in address byte

   // ==================================================================
   // select pin strap codes for the low target address bits
   localparam logic [2:0] SEL_GND       = 3'h0;
   localparam logic [2:0] SEL_SUPPLY    = 3'h1;
   localparam logic [2:0] SEL_SDA       = 3'h2;
   localparam logic [2:0] SEL_SCL       = 3'h3;

   // ==================================================================
   // framing and reset values
   localparam logic [3:0]  BYTE_BITS    = 4'h8;   // data bits before the ninth clock
   localparam logic [3:0]  LAST_TX_BIT  = 4'h7;
   localparam int          SYNC_STAGES  = 2;
   localparam int          FRAME_CLOCKS = 36;     // scl cycles of one full write
   localparam logic [7:0]  ADDR_RST     = 8'h00;
   localparam logic [15:0] DATA_RST     = 16'h0000;
   localparam logic [6:0]  TADDR_RST    = 7'h48;  // prefix with select bits 000

   // ==================================================================
   // types
   typedef enum logic [2:0] {
      ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK
   } i2ct_state_t;

   typedef enum logic [2:0] {
      PH_ADDR, PH_CMD, PH_DHI, PH_DLO, PH_APPLY, PH_GCALL, PH_GCRST, PH_READ
   } i2ct_phase_t;

   typedef struct packed {
      logic       scl;
      logic       sda;
      logic       sel;
   } i2ct_pins_t;

   typedef struct packed {
      logic       not_scl;   // select pin differed from scl at some sample
      logic       not_sda;   // select pin differed from sda at some sample
      logic       seen_lo;   // select pin seen low
   } i2ct_selflags_t;

endpackage : i2ct_pkg

/* File: i2ct_sync.sv */
`timescale 1ns/1ps

// two-stage synchroniser for the asynchronous bus and strap pins
module i2ct_sync #(
   parameter int W = 3
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // asynchronous in, synchronised out
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);

   logic [W-1:0] meta_q;

   // ==================================================================
   // first stage feeds only the second; idle bus level is high
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '1;
         q      <= '1;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule : i2ct_sync

/* File: i2ct_target.sv */
`timescale 1ns/1ps

module i2ct_target (
   // clock and reset
   input  wire logic        MCLK,
   input  wire logic        RST,
   // bus pins, open drain: enable high pulls the line low
   input  wire logic        SCL_I,
   input  wire logic        SDA_I,
   output logic             SDA_O,
   output logic             SDA_OE,
   // strap pin for the low address bits
   input  wire logic        ADDRESS_SELECT_PIN,
   // register side
   output logic [7:0]       REG_ADDR,
   output logic             REG_WR,
   output logic [15:0]      REG_WDATA,
   output logic             REG_RD,
   input  wire logic [15:0] REG_RDATA,
   // status
   output logic [6:0]       TARGET_ADDR,
   output logic             SW_RESET
);

   i2ct_pkg::i2ct_pins_t    pins_s;
   logic                    scl_d_q;
   logic                    sda_d_q;
   i2ct_pkg::i2ct_state_t   state_q;
   i2ct_pkg::i2ct_phase_t   phase_q;
   i2ct_pkg::i2ct_phase_t   phase_d;
   i2ct_pkg::i2ct_selflags_t flags_q;
   logic [3:0]              cnt_q;
   logic [7:0]              sh_q;
   logic [7:0]              tx_q;
   logic [7:0]              dhi_q;
   logic [7:0]              rdlo_q;
   logic                    lo_sent_q;
   logic                    ack_d;
   logic [2:0]              sel_d;
   logic [6:0]              own_addr;
   logic                    scl_rise;
   logic                    scl_fall;
   logic                    start_ev;
   logic                    stop_ev;

   // low address bits from what the select pin followed during the byte
   function automatic logic [2:0] sel_decode(input i2ct_pkg::i2ct_selflags_t f);
      if (!f.not_scl)
         return i2ct_pkg::SEL_SCL;
      else if (!f.not_sda)
         return i2ct_pkg::SEL_SDA;
      else if (!f.seen_lo)
         return i2ct_pkg::SEL_SUPPLY;
      else
         return i2ct_pkg::SEL_GND;
   endfunction : sel_decode

   // ==================================================================
   // pin synchronisation and bus events
   i2ct_sync #(
      .W ($bits(i2ct_pkg::i2ct_pins_t))
   ) u_sync (
      .clk (MCLK),
      .rst (RST),
      .d   ({SCL_I, SDA_I, ADDRESS_SELECT_PIN}),
      .q   (pins_s)
   );

   // delayed copies for edge detection, taken from the settled stage
   always_ff @(posedge MCLK) begin
      if (RST) begin
         scl_d_q <= 1'b1;
         sda_d_q <= 1'b1;
      end else begin
         scl_d_q <= pins_s.scl;
         sda_d_q <= pins_s.sda;
      end
   end

   assign scl_rise = pins_s.scl & ~scl_d_q;
   assign scl_fall = ~pins_s.scl & scl_d_q;
   assign start_ev = pins_s.scl & scl_d_q & sda_d_q & ~pins_s.sda;
   assign stop_ev  = pins_s.scl & scl_d_q & ~sda_d_q & pins_s.sda;

   // ==================================================================
   // select pin observation over the address byte
   // comparing the pin against both bus lines tells a strap to sda or scl
   // from a fixed level; the fixed 1001 prefix guarantees sda toggles
   always_ff @(posedge MCLK) begin
      if (RST) begin
         flags_q <= '0;
      end else if (start_ev) begin
         flags_q <= '0;
      end else if (state_q == i2ct_pkg::ST_RX && phase_q == i2ct_pkg::PH_ADDR) begin
         if (pins_s.sel != pins_s.scl)
            flags_q.not_scl <= 1'b1;
         if (pins_s.sel != pins_s.sda)
            flags_q.not_sda <= 1'b1;
         if (!pins_s.sel)
            flags_q.seen_lo <= 1'b1;
      end
   end

   assign sel_d    = sel_decode(flags_q);
   assign own_addr = {i2ct_pkg::ADDR_PREFIX, sel_d};

   // ==================================================================
   // byte decision at the end of the eighth bit
   always_comb begin
      ack_d   = 1'b0;
      phase_d = i2ct_pkg::PH_ADDR;
      unique case (phase_q)
         i2ct_pkg::PH_ADDR: begin
            // seven-bit compare only; ten-bit headers never match
            if (sh_q[7:1] == own_addr && sh_q[i2ct_pkg::RW_BIT]) begin
               ack_d   = 1'b1;
               phase_d = i2ct_pkg::PH_READ;
            end else if ((sh_q[7:1] == own_addr || sh_q[7:1] == i2ct_pkg::BCAST_ADDR)
                         && !sh_q[i2ct_pkg::RW_BIT]) begin
               ack_d   = 1'b1;
               phase_d = i2ct_pkg::PH_CMD;
            end else if (sh_q == i2ct_pkg::GCALL_BYTE) begin
               ack_d   = 1'b1;
               phase_d = i2ct_pkg::PH_GCALL;
            end
         end
         i2ct_pkg::PH_CMD: begin
            ack_d   = 1'b1;
            phase_d = i2ct_pkg::PH_DHI;
         end
         i2ct_pkg::PH_DHI: begin
            ack_d   = 1'b1;
            phase_d = i2ct_pkg::PH_DLO;
         end
         i2ct_pkg::PH_DLO: begin
            ack_d   = 1'b1;
            phase_d = i2ct_pkg::PH_APPLY;
         end
         i2ct_pkg::PH_GCALL: begin
            ack_d   = (sh_q == i2ct_pkg::GCALL_RESET);
            phase_d = i2ct_pkg::PH_GCRST;
         end
         // bytes beyond a complete write or reset are refused
         default: begin
            ack_d   = 1'b0;
            phase_d = i2ct_pkg::PH_ADDR;
         end
      endcase
   end

   // ==================================================================
   // transfer sequencer
   always_ff @(posedge MCLK) begin
      if (RST) begin
         state_q   <= i2ct_pkg::ST_IDLE;
         phase_q   <= i2ct_pkg::PH_ADDR;
         cnt_q     <= 4'h0;
         sh_q      <= 8'h00;
         tx_q      <= 8'h00;
         dhi_q     <= 8'h00;
         rdlo_q    <= 8'h00;
         lo_sent_q <= 1'b0;
         SDA_OE    <= 1'b0;
         REG_ADDR  <= i2ct_pkg::ADDR_RST;
         REG_WDATA <= i2ct_pkg::DATA_RST;
         TARGET_ADDR <= i2ct_pkg::TADDR_RST;
         REG_WR    <= 1'b0;
         REG_RD    <= 1'b0;
         SW_RESET  <= 1'b0;
      end else begin
         REG_WR   <= 1'b0;
         REG_RD   <= 1'b0;
         SW_RESET <= 1'b0;
         if (stop_ev) begin
            state_q <= i2ct_pkg::ST_IDLE;
            SDA_OE  <= 1'b0;
         end else if (start_ev) begin
            state_q <= i2ct_pkg::ST_RX;
            phase_q <= i2ct_pkg::PH_ADDR;
            cnt_q   <= 4'h0;
            SDA_OE  <= 1'b0;
         end else begin
            unique case (state_q)
               i2ct_pkg::ST_IDLE: begin
                  SDA_OE <= 1'b0;
               end
               i2ct_pkg::ST_RX: begin
                  if (scl_rise) begin
                     sh_q  <= {sh_q[6:0], pins_s.sda};
                     cnt_q <= cnt_q + 4'h1;
                  end else if (scl_fall && cnt_q == i2ct_pkg::BYTE_BITS) begin
                     cnt_q   <= 4'h0;
                     phase_q <= phase_d;
                     if (phase_q == i2ct_pkg::PH_ADDR)
                        TARGET_ADDR <= own_addr;
                     if (phase_q == i2ct_pkg::PH_CMD)
                        REG_ADDR <= sh_q;
                     if (phase_q == i2ct_pkg::PH_DHI)
                        dhi_q <= sh_q;
                     if (phase_q == i2ct_pkg::PH_DLO)
                        rdlo_q <= sh_q;
                     // refused bytes leave sda released until start or stop
                     SDA_OE  <= ack_d;
                     state_q <= ack_d ? i2ct_pkg::ST_ACK : i2ct_pkg::ST_IDLE;
                  end
               end
               i2ct_pkg::ST_ACK: begin
                  if (scl_rise) begin
                     if (phase_q == i2ct_pkg::PH_GCRST)
                        SW_RESET <= 1'b1;
                     if (phase_q == i2ct_pkg::PH_READ)
                        REG_RD <= 1'b1;
                  end else if (scl_fall) begin
                     if (phase_q == i2ct_pkg::PH_READ) begin
                        // data is captured once, so both bytes come from one value
                        rdlo_q    <= REG_RDATA[7:0];
                        tx_q      <= REG_RDATA[15:8];
                        SDA_OE    <= ~REG_RDATA[15];
                        lo_sent_q <= 1'b0;
                        state_q   <= i2ct_pkg::ST_TX;
                     end else begin
                        SDA_OE  <= 1'b0;
                        state_q <= i2ct_pkg::ST_RX;
                     end
                     if (phase_q == i2ct_pkg::PH_APPLY) begin
                        // one update per full frame bounds the output rate
                        REG_WR    <= 1'b1;
                        REG_WDATA <= {dhi_q, rdlo_q};
                     end
                  end
               end
               i2ct_pkg::ST_TX: begin
                  if (scl_fall) begin
                     if (cnt_q == i2ct_pkg::LAST_TX_BIT) begin
                        cnt_q   <= 4'h0;
                        SDA_OE  <= 1'b0;
                        state_q <= i2ct_pkg::ST_TXACK;
                     end else begin
                        cnt_q  <= cnt_q + 4'h1;
                        tx_q   <= {tx_q[6:0], 1'b0};
                        SDA_OE <= ~tx_q[6];
                     end
                  end
               end
               i2ct_pkg::ST_TXACK: begin
                  // a nack or the end of the low byte closes the read
                  if (scl_rise) begin
                     if (pins_s.sda || lo_sent_q)
                        state_q <= i2ct_pkg::ST_IDLE;
                  end else if (scl_fall) begin
                     tx_q      <= rdlo_q;
                     SDA_OE    <= ~rdlo_q[7];
                     lo_sent_q <= 1'b1;
                     state_q   <= i2ct_pkg::ST_TX;
                  end
               end
               default: begin
                  state_q <= i2ct_pkg::ST_IDLE;
                  SDA_OE  <= 1'b0;
               end
            endcase
         end
      end
   end

   // ==================================================================
   // open-drain data level is always low; only the enable moves
   always_ff @(posedge MCLK) begin
      SDA_O <= 1'b0;
   end

endmodule : i2ct_target

/* File: i2ct_target_props.sv */
`timescale 1ns/1ps

// ==========
// pin checks on the target
module i2ct_target_props (
   // clock and reset
   input logic       MCLK,
   input logic       RST,
   // bus
   input logic       SCL_I,
   input logic       SDA_I,
   input logic       SDA_OE,
   // register side and status
   input logic       REG_WR,
   input logic       REG_RD,
   input logic [6:0] TARGET_ADDR,
   input logic       SW_RESET
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);

   logic [7:0] low_q;

   // cycles since scl fell, saturating so it never wraps
   always_ff @(posedge MCLK) begin
      if (RST || SCL_I) low_q <= 8'h00;
      else if (low_q != 8'hFF) low_q <= low_q + 8'h01;
   end

   a_wr_one_cycle: assert property (REG_WR |=> !REG_WR)
      else $error("write strobe too long");
   a_rd_one_cycle: assert property (REG_RD |=> !REG_RD)
      else $error("read strobe too long");
   a_reset_pulse: assert property (SW_RESET |=> !SW_RESET)
      else $error("reset strobe too long");
   a_addr_prefix: assert property (TARGET_ADDR[6:3] == 4'h9)
      else $error("address prefix wrong");
   a_strap_codes: assert property (TARGET_ADDR[2] == 1'b0)
      else $error("strap code out of range");
   a_wr_at_fall: assert property (REG_WR |-> low_q inside {[8'h01:8'h08]})
      else $error("write not just after scl fall");
   a_wr_released: assert property (REG_WR |-> ##[0:2] !SDA_OE)
      else $error("ack held after write");
   a_oe_high_stable: assert property (SCL_I && $past(SCL_I) |-> $stable(SDA_OE))
      else $error("sda moved while scl high");
   a_stop_idle: assert property (SCL_I && $past(SCL_I) && $rose(SDA_I) |-> !SDA_OE[*8])
      else $error("sda driven after stop");
   a_rd_in_ack: assert property (REG_RD |-> SCL_I && SDA_OE)
      else $error("read strobe outside ack");
endmodule : i2ct_target_props
